// ===== rtl/sbes_pkg.sv
package sbes_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS_TWO = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_STATUS_ONE = 8'h0c;
  localparam logic [7:0] OFS_RX_DATA = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_BRK_FLAG = 7;
  localparam int BIT_EDGE_FLAG = 6;
  localparam int BIT_RX_INV = 4;
  localparam int BIT_IDLE_WU = 3;
  localparam int BIT_LONG_BRK = 2;
  localparam int BIT_BRK_EN = 1;
  localparam int BIT_NINE = 0;
  localparam int BIT_STANDBY = 1;
  localparam int BIT_SEND_BRK = 2;
  localparam int BIT_RXF = 0;
  localparam int BIT_FE = 1;
  localparam int BIT_IDLE = 2;
  localparam int IRQ_W = 6;
  localparam int IRQ_BRK = 0;
  localparam int IRQ_EDGE = 1;
  localparam int IRQ_RXF = 2;
  localparam int IRQ_FE = 3;
  localparam int IRQ_IDLE = 4;
  localparam int IRQ_TXDONE = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_BAUD = 16'h0010;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 6'h00;
  localparam logic RST_LINE = 1'b1;

  // ----------------------------------------------------------------
  // bit counts
  // ----------------------------------------------------------------
  localparam logic [3:0] BRK_TX_SHORT = 4'ha;
  localparam logic [3:0] BRK_TX_SHORT_NINE = 4'hb;
  localparam logic [3:0] BRK_TX_LONG = 4'hd;
  localparam logic [3:0] BRK_TX_LONG_NINE = 4'he;
  localparam logic [3:0] BRK_DET_BITS = 4'hb;
  localparam logic [3:0] BRK_DET_BITS_NINE = 4'hc;
  localparam logic [3:0] CHAR_BITS = 4'ha;
  localparam logic [3:0] CHAR_BITS_NINE = 4'hb;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] DATA_BITS_NINE = 4'h9;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_STOP = 5'h08,
    RX_WAIT = 5'h10
  } sbes_rx_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_BREAK = 2'h2
  } sbes_tx_t;

  // bits times divisor, in clock cycles
  function automatic logic [19:0] sbes_cycles(input logic [3:0] bits, input logic [15:0] div);
    sbes_cycles = 20'(bits) * 20'(div);
  endfunction : sbes_cycles

endpackage : sbes_pkg

// ===== rtl/sbes_sync.sv
module sbes_sync
  import sbes_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sbes_sync_t;

  sbes_sync_t s;
  sbes_sync_t next_s;

  // ----------------------------------------------------------------
  // three stages, change taken once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.level = s.s3;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '{s1: RST_LINE, s2: RST_LINE, s3: RST_LINE, level: RST_LINE};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule : sbes_sync

// ===== rtl/sbes_top.sv
// What this block does
// (RQ1) break flag sets on detected break when enabled
// (RQ2) writing one clears break flag, zero ignored
// (RQ3) edge flag on active edge, polarity follows invert
// (RQ4) edge flag holds until software writes one
// (RQ5) invert setting flips received data before processing
// (RQ6) wakeup setting zero: standby idle sets no flag
// (RQ7) wakeup setting one: standby idle sets flag
// (RQ8) short break transmits ten or eleven bits
// (RQ9) long break transmits thirteen or fourteen bits
// (RQ10) framing detection ignores long break setting
// (RQ11) break detect length exceeds a normal character
// (RQ12) break detect enabled blocks framing and full
// (RQ13) zero at stop bit sets framing with full
// (RQ14) break is eleven or twelve low bits
module sbes_top
  import sbes_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  output logic txd,
  output logic irq
);

  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic break_detect_flag;
    logic receive_edge_flag;
    logic receive_invert;
    logic idle_wakeup_flag_enable;
    logic long_break_transmit;
    logic break_detect_enable;
    logic nine_bit;
    logic receiver_standby;
    logic [15:0] baud_div;
    logic receive_full_flag;
    logic framing_error_flag;
    logic idle_flag;
    logic [8:0] rx_data;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic rx_prev;
    sbes_rx_t rx_state;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic [19:0] low_cnt;
    logic [19:0] high_cnt;
    logic idle_armed;
    sbes_tx_t tx_state;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bits;
    logic txd;
  } sbes_state_t;

  sbes_state_t s;
  sbes_state_t next_s;
  logic rx_pin;

  sbes_sync u_rx_sync (
    .mclk(mclk),
    .rst(rst),
    .pin(rxd),
    .level(rx_pin)
  );

  always_comb begin
    logic rxi;
    logic ev_brk;
    logic ev_edge;
    logic ev_rxf;
    logic ev_fe;
    logic ev_idle;
    logic ev_txdone;
    logic [3:0] n_data;
    logic [3:0] n_brk_det;
    logic [3:0] n_char;
    logic [3:0] n_tx_brk;
    rxi = 1'b0;
    ev_brk = 1'b0;
    ev_edge = 1'b0;
    ev_rxf = 1'b0;
    ev_fe = 1'b0;
    ev_idle = 1'b0;
    ev_txdone = 1'b0;
    n_data = s.nine_bit ? DATA_BITS_NINE : DATA_BITS;
    n_brk_det = s.nine_bit ? BRK_DET_BITS_NINE : BRK_DET_BITS;
    n_char = s.nine_bit ? CHAR_BITS_NINE : CHAR_BITS;
    n_tx_brk = s.long_break_transmit ? (s.nine_bit ? BRK_TX_LONG_NINE : BRK_TX_LONG) : // RQ9
        (s.nine_bit ? BRK_TX_SHORT_NINE : BRK_TX_SHORT); // RQ8
    next_s = s;

    // ----------------------------------------------------------------
    // write channels
    // ----------------------------------------------------------------
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s.aw_addr)
        OFS_STATUS_TWO: begin
          if (s.w_strb[0]) begin
            if (s.w_data[BIT_BRK_FLAG]) begin
              next_s.break_detect_flag = 1'b0; // RQ2
            end
            if (s.w_data[BIT_EDGE_FLAG]) begin
              next_s.receive_edge_flag = 1'b0; // RQ4
            end
            next_s.receive_invert = s.w_data[BIT_RX_INV];
            next_s.idle_wakeup_flag_enable = s.w_data[BIT_IDLE_WU];
            next_s.long_break_transmit = s.w_data[BIT_LONG_BRK];
            next_s.break_detect_enable = s.w_data[BIT_BRK_EN];
          end
        end
        OFS_CONTROL: begin
          if (s.w_strb[0]) begin
            next_s.nine_bit = s.w_data[BIT_NINE];
            next_s.receiver_standby = s.w_data[BIT_STANDBY];
            if (s.w_data[BIT_SEND_BRK] && s.tx_state == TX_IDLE) begin
              next_s.tx_state = TX_BREAK;
              next_s.tx_cnt = s.baud_div - 16'h0001;
              next_s.tx_bits = n_tx_brk; // RQ8 RQ9
              next_s.txd = 1'b0;
            end
          end
        end
        OFS_BAUD: begin
          if (s.w_strb[0]) begin
            next_s.baud_div[7:0] = s.w_data[7:0];
          end
          if (s.w_strb[1]) begin
            next_s.baud_div[15:8] = s.w_data[15:8];
          end
        end
        OFS_IRQ_MASK: begin
          if (s.w_strb[0]) begin
            next_s.irq_mask = s.w_data[IRQ_W-1:0];
          end
        end
        OFS_STATUS_ONE, OFS_RX_DATA, OFS_IRQ_STATUS: begin
          next_s.bresp = RESP_OKAY;
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // read channel, reads with side effects
    // ----------------------------------------------------------------
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFS_STATUS_TWO: begin
          next_s.rdata[BIT_BRK_FLAG] = s.break_detect_flag;
          next_s.rdata[BIT_EDGE_FLAG] = s.receive_edge_flag;
          next_s.rdata[BIT_RX_INV] = s.receive_invert;
          next_s.rdata[BIT_IDLE_WU] = s.idle_wakeup_flag_enable;
          next_s.rdata[BIT_LONG_BRK] = s.long_break_transmit;
          next_s.rdata[BIT_BRK_EN] = s.break_detect_enable;
        end
        OFS_CONTROL: begin
          next_s.rdata[BIT_NINE] = s.nine_bit;
          next_s.rdata[BIT_STANDBY] = s.receiver_standby;
          next_s.rdata[BIT_SEND_BRK] = (s.tx_state == TX_BREAK);
        end
        OFS_BAUD: begin
          next_s.rdata[15:0] = s.baud_div;
        end
        OFS_STATUS_ONE: begin
          next_s.rdata[BIT_RXF] = s.receive_full_flag;
          next_s.rdata[BIT_FE] = s.framing_error_flag;
          next_s.rdata[BIT_IDLE] = s.idle_flag;
          next_s.idle_flag = 1'b0;
        end
        OFS_RX_DATA: begin
          next_s.rdata[8:0] = s.rx_data;
          next_s.receive_full_flag = 1'b0;
          next_s.framing_error_flag = 1'b0;
        end
        OFS_IRQ_STATUS: begin
          next_s.rdata[IRQ_W-1:0] = s.irq_stat;
          next_s.irq_stat = '0;
        end
        OFS_IRQ_MASK: begin
          next_s.rdata[IRQ_W-1:0] = s.irq_mask;
        end
        default: begin
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // receive line, edge and break watch
    // ----------------------------------------------------------------
    rxi = rx_pin ^ s.receive_invert; // RQ5
    next_s.rx_prev = rx_pin;
    if (s.receive_invert ? (!s.rx_prev && rx_pin) : (s.rx_prev && !rx_pin)) begin
      ev_edge = 1'b1; // RQ3
    end
    if (rxi) begin
      next_s.low_cnt = 20'h00000;
    end else if (s.low_cnt != 20'hfffff) begin
      next_s.low_cnt = s.low_cnt + 20'h00001;
    end
    // one past a whole character of zeros, so a zero byte never matches
    if (!rxi && s.break_detect_enable && s.low_cnt == sbes_cycles(n_brk_det, s.baud_div) - 20'h00001) begin
      ev_brk = 1'b1; // RQ1 RQ11 RQ14
    end
    if (!rxi) begin
      next_s.high_cnt = 20'h00000;
    end else if (s.high_cnt != 20'hfffff) begin
      next_s.high_cnt = s.high_cnt + 20'h00001;
    end
    if (rxi && s.idle_armed && s.high_cnt == sbes_cycles(n_char, s.baud_div) - 20'h00001) begin
      next_s.idle_armed = 1'b0;
      if (s.receiver_standby) begin
        next_s.receiver_standby = 1'b0;
        ev_idle = s.idle_wakeup_flag_enable; // RQ6 RQ7
      end else begin
        ev_idle = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // receive framing
    // ----------------------------------------------------------------
    if (s.rx_cnt != 16'h0000) begin
      next_s.rx_cnt = s.rx_cnt - 16'h0001;
    end
    unique case (s.rx_state)
      RX_IDLE: begin
        if (!rxi) begin
          next_s.rx_state = RX_START;
          next_s.rx_cnt = s.baud_div >> 1;
        end
      end
      RX_START: begin
        if (s.rx_cnt == 16'h0000) begin
          next_s.rx_state = rxi ? RX_IDLE : RX_DATA;
          next_s.rx_cnt = s.baud_div - 16'h0001;
          next_s.rx_bit = 4'h0;
        end
      end
      RX_DATA: begin
        if (s.rx_cnt == 16'h0000) begin
          next_s.rx_shift = {rxi, s.rx_shift[8:1]};
          next_s.rx_bit = s.rx_bit + 4'h1;
          next_s.rx_cnt = s.baud_div - 16'h0001;
          if (s.rx_bit == n_data - 4'h1) begin
            next_s.rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (s.rx_cnt == 16'h0000) begin
          next_s.rx_state = rxi ? RX_IDLE : RX_WAIT;
          next_s.idle_armed = 1'b1;
          // long break setting plays no part here
          if (!s.break_detect_enable && !s.receiver_standby) begin // RQ10 RQ12
            next_s.rx_data = s.nine_bit ? s.rx_shift : {1'b0, s.rx_shift[8:1]};
            ev_rxf = 1'b1; // RQ13
            ev_fe = !rxi; // RQ13
          end
        end
      end
      RX_WAIT: begin
        if (rxi) begin
          next_s.rx_state = RX_IDLE;
        end
      end
      default: begin
        next_s.rx_state = RX_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // break transmitter
    // ----------------------------------------------------------------
    unique case (s.tx_state)
      TX_IDLE: begin
        // keep the count and bits loaded by a control write, line low only then
        next_s.txd = (next_s.tx_state == TX_IDLE);
      end
      TX_BREAK: begin
        if (s.tx_cnt != 16'h0000) begin
          next_s.tx_cnt = s.tx_cnt - 16'h0001;
        end else if (s.tx_bits == 4'h1) begin
          next_s.tx_state = TX_IDLE;
          next_s.txd = 1'b1;
          ev_txdone = 1'b1;
        end else begin
          next_s.tx_bits = s.tx_bits - 4'h1;
          next_s.tx_cnt = s.baud_div - 16'h0001;
        end
      end
      default: begin
        next_s.tx_state = TX_IDLE;
        next_s.txd = 1'b1;
      end
    endcase

    // ----------------------------------------------------------------
    // hardware sets win over clears
    // ----------------------------------------------------------------
    if (ev_brk) begin
      next_s.break_detect_flag = 1'b1; // RQ1
    end
    if (ev_edge) begin
      next_s.receive_edge_flag = 1'b1; // RQ3 RQ4
    end
    if (ev_rxf) begin
      next_s.receive_full_flag = 1'b1;
    end
    if (ev_fe) begin
      next_s.framing_error_flag = 1'b1;
    end
    if (ev_idle) begin
      next_s.idle_flag = 1'b1;
    end
    next_s.irq_stat[IRQ_BRK] = next_s.irq_stat[IRQ_BRK] | ev_brk;
    next_s.irq_stat[IRQ_EDGE] = next_s.irq_stat[IRQ_EDGE] | ev_edge;
    next_s.irq_stat[IRQ_RXF] = next_s.irq_stat[IRQ_RXF] | ev_rxf;
    next_s.irq_stat[IRQ_FE] = next_s.irq_stat[IRQ_FE] | ev_fe;
    next_s.irq_stat[IRQ_IDLE] = next_s.irq_stat[IRQ_IDLE] | ev_idle;
    next_s.irq_stat[IRQ_TXDONE] = next_s.irq_stat[IRQ_TXDONE] | ev_txdone;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.baud_div <= RST_BAUD;
      s.irq_mask <= RST_IRQ_MASK;
      s.rx_prev <= RST_LINE;
      s.rx_state <= RX_IDLE;
      s.tx_state <= TX_IDLE;
      s.txd <= RST_LINE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign txd = s.txd;
  assign irq = |(s.irq_stat & s.irq_mask);

endmodule : sbes_top

// ===== testbench/sbes_lin_model.sv
module sbes_lin_model #(
  parameter int DIV = 4
) (
  input wire logic mclk,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // line driver, recessive high between frames, low after an inverted frame
  // ------------------------------------------------------------
  initial rxd = 1'b1;

  task automatic hold(input logic lvl, input int n);
    rxd <= lvl;
    repeat (n * DIV) @(posedge mclk);
  endtask : hold

  // lsb first; inv drives the complement of every level
  task automatic send(input logic [8:0] data, input int nbits, input logic stop, input logic inv);
    hold(inv, 1);
    for (int i = 0; i < nbits; i++) hold(data[i] ^ inv, 1);
    hold(stop ^ inv, 1);
    hold(!inv, 2);
  endtask : send
endmodule : sbes_lin_model

// ===== testbench/sbes_top_chk.sv
module sbes_top_chk
  import sbes_pkg::*;
#(
  parameter int DIV = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // length of the current low run on txd
  // ------------------------------------------------------------
  int low_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= txd ? 0 : low_cnt + 1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_break_length: assert property (
    $rose(txd) |-> low_cnt inside {10 * DIV, 11 * DIV, 13 * DIV, 14 * DIV}) else $error("break length wrong");
  a_break_start: assert property ($fell(txd) |-> s_axi_bvalid) else $error("break without request");
endmodule : sbes_top_chk

// ===== testbench/serial_break_edge_status_tb_top.sv
module serial_break_edge_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sbes_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int DIV = 4;
  localparam int LIM = 400;
  logic mclk = 1'b0, rst = 1'b1, lag = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, rxd, txd, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, bv;
  int bad_count, checked, low_run, last_run, tn;
  int blen[4] = '{10, 11, 13, 14};

  sbes_top DUT (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .irq);
  sbes_lin_model #(.DIV(DIV)) lin (.mclk, .rxd);

  always #2 mclk = ~mclk;

  always @(posedge mclk) begin
    if (txd === 1'b0) begin
      low_run <= low_run + 1;
    end else begin
      if (low_run != 0) last_run <= low_run;
      low_run <= 0;
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic timed_out(input int n);
    if (n >= LIM) begin
      bad_count++;
      final_report();
    end
  endtask : timed_out

  // lag holds the ready low until the answer is seen
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    int n;
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !lag;
    for (n = 0; n < LIM; n++) begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
      if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
    end
    timed_out(n);
    bv = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] addr);
    int n;
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !lag;
    for (n = 0; n < LIM; n++) begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
      if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
    end
    timed_out(n);
    rv = s_axi_rdata;
    bv = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask : rd

  task automatic rc(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp, input string s);
    rd(addr);
    check(s, rv & mask, exp);
  endtask : rc

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rc(OFS_STATUS_TWO, 32'hff, 32'h0, "st2 reset");
    rc(OFS_BAUD, 32'hffff, 32'(RST_BAUD), "baud reset");
    rc(OFS_IRQ_MASK, 32'h3f, 32'(RST_IRQ_MASK), "mask reset");
    rd(8'h40);
    check("unmapped rd", 32'(bv), 32'(RESP_SLVERR));
    wr(8'h40, 32'h1);
    check("unmapped wr", 32'(bv), 32'(RESP_SLVERR));
    lag <= 1'b0;
    wr(OFS_BAUD, 32'(DIV));
    wr(OFS_IRQ_MASK, 32'h4);
    check("irq quiet", 32'(irq), 32'h0);
    $display("test reset done");
    lin.send(9'h05a, 8, 1'b1, 1'b0);
    rc(OFS_STATUS_ONE, 32'h3, 32'h1, "full only");
    check("irq raised", 32'(irq), 32'h1);
    rc(OFS_IRQ_STATUS, 32'h4, 32'h4, "irq full");
    check("irq cleared", 32'(irq), 32'h0);
    rc(OFS_RX_DATA, 32'hff, 32'h5a, "data");
    rc(OFS_STATUS_TWO, 32'h40, 32'h40, "edge set");
    wr(OFS_STATUS_TWO, 32'h0);
    rc(OFS_STATUS_TWO, 32'h40, 32'h40, "edge holds");
    wr(OFS_STATUS_TWO, 32'h40);
    rc(OFS_STATUS_TWO, 32'h40, 32'h0, "edge clear");
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_STATUS_TWO, 32'h4);
    lin.send(9'h03c, 8, 1'b0, 1'b0);
    rc(OFS_STATUS_ONE, 32'h3, 32'h3, "framing");
    check("irq masked", 32'(irq), 32'h0);
    wr(OFS_IRQ_MASK, 32'h4);
    check("irq unmasked", 32'(irq), 32'h1);
    rd(OFS_IRQ_STATUS);
    rd(OFS_RX_DATA);
    wr(OFS_STATUS_TWO, 32'h10);
    wr(OFS_STATUS_TWO, 32'h50);
    lin.hold(1'b0, 14);
    rc(OFS_STATUS_TWO, 32'h40, 32'h0, "no edge inv fall");
    rd(OFS_RX_DATA);
    lin.send(9'h0a5, 8, 1'b1, 1'b1);
    rc(OFS_STATUS_TWO, 32'h40, 32'h40, "edge inv rise");
    rc(OFS_STATUS_ONE, 32'h3, 32'h1, "inv frame");
    rc(OFS_RX_DATA, 32'hff, 32'ha5, "inv data");
    wr(OFS_STATUS_TWO, 32'h0);
    lin.hold(1'b1, 14);
    rd(OFS_RX_DATA);
    $display("test receive done");
    wr(OFS_STATUS_TWO, 32'h2);
    lin.send(9'h000, 8, 1'b0, 1'b0);
    rc(OFS_STATUS_TWO, 32'h80, 32'h0, "ten low no break");
    rc(OFS_STATUS_ONE, 32'h3, 32'h0, "zero char blocked");
    lin.hold(1'b0, 12);
    lin.hold(1'b1, 2);
    rc(OFS_STATUS_TWO, 32'h80, 32'h80, "break set");
    rc(OFS_STATUS_ONE, 32'h3, 32'h0, "break blocked");
    wr(OFS_STATUS_TWO, 32'h2);
    rc(OFS_STATUS_TWO, 32'h80, 32'h80, "break holds");
    wr(OFS_STATUS_TWO, 32'h82);
    rc(OFS_STATUS_TWO, 32'h80, 32'h0, "break clear");
    wr(OFS_STATUS_TWO, 32'h0);
    $display("test break detect done");
    for (int w = 0; w < 2; w++) begin
      lin.hold(1'b1, 15);
      wr(OFS_STATUS_TWO, 32'(w << 3));
      wr(OFS_CONTROL, 32'h2);
      rd(OFS_STATUS_ONE);
      lin.send(9'h055, 8, 1'b1, 1'b0);
      lin.hold(1'b1, 12);
      rc(OFS_STATUS_ONE, 32'h4, 32'(w << 2), "standby idle");
      rc(OFS_CONTROL, 32'h2, 32'h0, "woken");
    end
    $display("test idle done");
    for (int k = 0; k < 4; k++) begin
      wr(OFS_STATUS_TWO, 32'(k[1]) << 2);
      // format first, the break length follows the format already in force
      wr(OFS_CONTROL, 32'(k[0]));
      wr(OFS_CONTROL, 32'h4 | 32'(k[0]));
      rc(OFS_CONTROL, 32'h4, 32'h4, "break busy");
      for (tn = 0; tn < LIM && txd !== 1'b1; tn++) @(posedge mclk);
      timed_out(tn);
      repeat (2) @(posedge mclk);
      check("break length", 32'(last_run), 32'(blen[k] * DIV));
      rc(OFS_IRQ_STATUS, 32'h20, 32'h20, "tx done");
    end
    wr(OFS_CONTROL, 32'h0);
    $display("test break transmit done");
    final_report();
  end
endmodule : serial_break_edge_status_tb_top

bind sbes_top sbes_top_chk #(.DIV(4)) u_chk (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd);
